//--- fpc_pkg.sv
// Constants, register map and command codes of the flash protection control block
// Notes on behaviour
// - Top protection bit blocks debug-port flash reads
// - Other 31 bits each guard 2 kB
// - Guarded groups refuse writes from every path but mass erase
// - Volatile protection acts now, lost on reset
// - Persistent protection acts after save and reset
// - Persistent protection guarded by stored key
// - Mass erase restores blank key, drops stored protection
// - Permanent key blocks further saves until a mass erase
// - Interrupt flag on completion, cleared by read
// - Busy flag follows controller activity
// - Fail flag on bad completion, read clears
// - Pass flag on good completion, read clears
// - Mode interrupt enable gates completion interrupt
// - Mode write enable gates erase and write
// - Status register read-only, upper bits reserved
package fpc_pkg;

  // Register byte addresses
  localparam logic [31:0] FPC_STATUS_ADDR   = 32'hFFFFF800;
  localparam logic [31:0] FPC_MODE_ADDR     = 32'hFFFFF804;
  localparam logic [31:0] FPC_COMMAND_ADDR  = 32'hFFFFF808;
  localparam logic [31:0] FPC_DATA_ADDR     = 32'hFFFFF80C;
  localparam logic [31:0] FPC_ADDRESS_ADDR  = 32'hFFFFF810;
  localparam logic [31:0] FPC_VOLATILE_ADDR = 32'hFFFFF81C;
  localparam logic [31:0] FPC_PERSIST_ADDR  = 32'hFFFFF820;

  // Reset values
  localparam logic [15:0] FPC_STATUS_RST = 16'h0020;
  localparam logic [15:0] FPC_MODE_RST   = 16'h0000;
  localparam logic [31:0] FPC_PROT_RST   = 32'h00000000;

  // Status bit positions
  localparam int FPC_ST_PASS = 0;
  localparam int FPC_ST_FAIL = 1;
  localparam int FPC_ST_BUSY = 2;
  localparam int FPC_ST_IRQ  = 3;

  // Mode bit positions and implemented mask
  localparam int          FPC_MD_WREN   = 3;
  localparam int          FPC_MD_IRQEN  = 4;
  localparam int          FPC_MD_KEYLO  = 5;
  localparam int          FPC_MD_KEYEN  = 6;
  localparam logic [15:0] FPC_MODE_MASK = 16'h01FF;

  // Protection word layout
  localparam int FPC_JTAG_BIT = 31;
  localparam int FPC_GROUPS   = 31;
  localparam int FPC_GRP_LSB  = 11;
  localparam int FPC_GRP_W    = 5;

  // Command codes
  localparam logic [7:0] FPC_CMD_READ  = 8'h01;
  localparam logic [7:0] FPC_CMD_WRITE = 8'h02;
  localparam logic [7:0] FPC_CMD_PERAS = 8'h05;
  localparam logic [7:0] FPC_CMD_MERAS = 8'h06;
  localparam logic [7:0] FPC_CMD_SAVE  = 8'h0C;

  // Key values
  localparam logic [31:0] FPC_KEY_BLANK = 32'hFFFFFFFF;
  localparam logic [31:0] FPC_KEY_PERM  = 32'hDEADDEAD;

  // Command duration
  localparam int CLK_MHZ     = 125;
  localparam int CMD_TIME_NS = 200;
  localparam int CMD_CYCLES  = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;

  // Flash array operation codes
  typedef enum logic [1:0] {
    FPC_OP_READ  = 2'h0,
    FPC_OP_WRITE = 2'h1,
    FPC_OP_PERAS = 2'h2,
    FPC_OP_MERAS = 2'h3
  } fpc_op_e;

endpackage

//--- fpc_cmd_timer.sv
// Command duration timer: done pulse a fixed number of cycles after start
`timescale 1ns/10ps
module fpc_cmd_timer #(
  parameter int CYCLES = 25
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  // Refuse a zero-length command at elaboration
  if (CYCLES < 1) begin : g_cyc_check
    $error("CYCLES must be at least one");
  end

  logic [CW-1:0] cnt_reg;   // Cycles left
  logic [CW-1:0] cnt_next;

  // Load on start, count down, done on the last cycle
  always_comb begin
    cnt_next = cnt_reg;
    done     = 1'b0;
    if (start) begin
      cnt_next = CW'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CW'(1);
      done     = (cnt_reg == CW'(1));
    end
  end

  // Counter register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

//--- fpc_key_store.sv
// Non-volatile key and protection cells, kept across system reset
`timescale 1ns/10ps
module fpc_key_store
  import fpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        por_b,
  input  wire logic        save,
  input  wire logic        erase,
  input  wire logic [31:0] new_key,
  input  wire logic [31:0] new_prot,
  output logic [31:0]      key,
  output logic [31:0]      prot,
  output logic             locked
);

  logic [31:0] key_reg;    // Stored key
  logic [31:0] key_next;
  logic [31:0] prot_reg;   // Stored protection word
  logic [31:0] prot_next;

  // Erase wins over save; erase restores a blank part
  always_comb begin
    key_next  = key_reg;
    prot_next = prot_reg;
    if (erase) begin
      key_next  = FPC_KEY_BLANK;
      prot_next = FPC_PROT_RST;
    end else if (save) begin
      key_next  = new_key;
      prot_next = new_prot;
    end
  end

  // Only power-on and mass erase clear these cells, standing in for the flash store
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      key_reg  <= FPC_KEY_BLANK;
      prot_reg <= FPC_PROT_RST;
    end else begin
      key_reg  <= key_next;
      prot_reg <= prot_next;
    end
  end

  assign key    = key_reg;
  assign prot   = prot_reg;
  assign locked = (key_reg == FPC_KEY_PERM);

endmodule

//--- fpc_top.sv
// Flash protection and command-status controller with register port
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module fpc_top
  import fpc_pkg::*;
#(
  parameter int CMD_CYC = CMD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        por_b,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [31:0]      rdata,
  output logic             flash_irq,
  output logic             jtag_read_lock,
  output logic [30:0]      write_protect,
  output logic             array_start,
  output logic [1:0]       array_op,
  output logic [15:0]      array_addr,
  output logic [15:0]      array_data
);

  // Refuse timers the counter cannot serve
  if (CMD_CYC < 1) begin : g_cyc_check
    $error("CMD_CYC must be at least one");
  end

  typedef enum logic {
    FPC_IDLE = 1'b0,
    FPC_RUN  = 1'b1
  } fpc_state_e;

  // Address match helper, used by every decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // Page group protection check for a flash address
  function automatic logic grp_prot(input logic [15:0] a, input logic [31:0] p);
    logic [FPC_GRP_W-1:0] g;
    g = a[FPC_GRP_LSB +: FPC_GRP_W];
    // Group beyond the user area counts as protected
    grp_prot = (32'(g) >= FPC_GROUPS) ? 1'b1 : p[g];
  endfunction

  // Register state
  logic [15:0] mode_reg;          // Mode bits
  logic [15:0] mode_next;
  logic [15:0] addr_reg;          // Flash address / key high half
  logic [15:0] addr_next;
  logic [15:0] data_reg;          // Flash data / key low half
  logic [15:0] data_next;
  logic [31:0] vol_prot_reg;      // Volatile protection
  logic [31:0] vol_prot_next;
  logic [31:0] per_prot_reg;      // Staged persistent protection
  logic [31:0] per_prot_next;
  logic [31:0] act_prot_reg;      // Persistent protection in force
  logic [31:0] act_prot_next;
  logic        loaded_reg;        // Persistent word copied since reset
  logic        loaded_next;
  logic [3:0]  status_reg;        // Irq, busy, fail, pass
  logic [3:0]  status_next;
  logic [31:0] rdata_reg;         // Read data, one cycle after strobe
  logic [31:0] rdata_next;

  // Command state
  fpc_state_e  state_reg;
  fpc_state_e  state_next;
  logic [7:0]  cmd_reg;           // Command in progress
  logic [7:0]  cmd_next;
  logic        cmd_ok_reg;        // Command will pass
  logic        cmd_ok_next;
  logic        start_reg;         // Timer start pulse
  logic        start_next;
  logic [1:0]  op_reg;            // Array operation
  logic [1:0]  op_next;
  logic [30:0] wp_reg;            // Group write protection out
  logic        jtag_reg;          // Debug-port read lock out

  // Glue
  logic        timer_done;        // Command finished
  logic        cmd_wr;            // Command register written while idle
  logic [31:0] nv_key;            // Stored key
  logic [31:0] nv_prot;           // Stored protection
  logic        nv_locked;         // Permanent key stored
  logic        nv_save;           // Save key and protection
  logic        nv_erase;          // Mass erase of key store
  logic [31:0] eff_prot;          // Combined protection
  logic [31:0] key_in;            // Key offered by software
  logic        key_ok;            // Key allows a save

  assign eff_prot = vol_prot_reg | act_prot_reg;
  assign key_in   = {addr_reg, data_reg};
  assign cmd_wr   = wr_stb && hit(addr, FPC_COMMAND_ADDR) && (state_reg == FPC_IDLE);

  // Unless the permanent key is stored: blank store accepts any key, otherwise the same key again
  assign key_ok = !nv_locked
                  && ((nv_key == FPC_KEY_BLANK) || (nv_key == key_in));

  // Store effects land on the completion cycle of a passing command
  assign nv_save  = (state_reg == FPC_RUN) && timer_done && cmd_ok_reg
                    && (cmd_reg == FPC_CMD_SAVE);
  assign nv_erase = (state_reg == FPC_RUN) && timer_done && cmd_ok_reg
                    && (cmd_reg == FPC_CMD_MERAS);

  // Command duration
  fpc_cmd_timer #(
    .CYCLES (CMD_CYC)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (start_reg),
    .done  (timer_done)
  );

  // Key and persistent protection cells
  fpc_key_store u_store (
    .clk      (clk),
    .por_b    (por_b),
    .save     (nv_save),
    .erase    (nv_erase),
    .new_key  (key_in),
    .new_prot (per_prot_reg),
    .key      (nv_key),
    .prot     (nv_prot),
    .locked   (nv_locked)
  );

  // Command sequencer: acceptance check, run, completion
  always_comb begin
    state_next  = state_reg;
    cmd_next    = cmd_reg;
    cmd_ok_next = cmd_ok_reg;
    start_next  = 1'b0;
    op_next     = op_reg;
    case (state_reg)
      FPC_IDLE: begin
        // Writes while busy are dropped by the idle qualifier
        if (cmd_wr) begin
          state_next  = FPC_RUN;
          cmd_next    = wdata[7:0];
          start_next  = 1'b1;
          cmd_ok_next = 1'b1;
          case (wdata[7:0])
            FPC_CMD_READ: begin
              op_next = FPC_OP_READ;
            end
            FPC_CMD_WRITE, FPC_CMD_PERAS: begin
              op_next     = (wdata[7:0] == FPC_CMD_WRITE) ? FPC_OP_WRITE : FPC_OP_PERAS;
              cmd_ok_next = mode_reg[FPC_MD_WREN]
                            && !grp_prot(addr_reg, eff_prot);
              start_next  = cmd_ok_next;            // Refused ones never reach the array
            end
            FPC_CMD_MERAS: begin
              // Mass erase is the one way past protection
              op_next     = FPC_OP_MERAS;
              cmd_ok_next = mode_reg[FPC_MD_WREN];
              start_next  = cmd_ok_next;
            end
            FPC_CMD_SAVE: begin
              op_next     = op_reg;
              cmd_ok_next = mode_reg[FPC_MD_KEYEN]
                            && !mode_reg[FPC_MD_KEYLO] && key_ok;
              start_next  = 1'b0;                   // Key save stays internal
            end
            default: begin
              cmd_ok_next = 1'b0;                   // Unknown command fails
              start_next  = 1'b0;
            end
          endcase
        end
      end
      FPC_RUN: begin
        if (timer_done) begin
          state_next = FPC_IDLE;
        end
      end
      default: begin
        state_next = FPC_IDLE;
      end
    endcase
  end

  // Timer start also for commands that skip the array
  logic timer_kick;
  assign timer_kick = cmd_wr;

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= FPC_IDLE;
      cmd_reg    <= 8'h00;
      cmd_ok_reg <= 1'b0;
      start_reg  <= 1'b0;
      op_reg     <= FPC_OP_READ;
    end else begin
      state_reg  <= state_next;
      cmd_reg    <= cmd_next;
      cmd_ok_reg <= cmd_ok_next;
      start_reg  <= timer_kick;
      op_reg     <= op_next;
    end
  end

  // Array strobe only for commands that were allowed
  logic arr_start_reg;
  logic arr_start_next;
  assign arr_start_next = start_next;

  // Software registers, status flags and read data
  always_comb begin
    mode_next     = mode_reg;
    addr_next     = addr_reg;
    data_next     = data_reg;
    vol_prot_next = vol_prot_reg;
    per_prot_next = per_prot_reg;
    act_prot_next = act_prot_reg;
    loaded_next   = 1'b1;
    status_next   = status_reg;
    rdata_next    = 32'h00000000;

    // Persistent word takes hold once, just after reset release
    if (!loaded_reg) begin
      act_prot_next = nv_prot;
    end

    // Register writes; status has no write path
    if (wr_stb) begin
      if (hit(addr, FPC_MODE_ADDR)) begin
        mode_next = wdata[15:0] & FPC_MODE_MASK;
      end
      if (hit(addr, FPC_ADDRESS_ADDR)) begin
        addr_next = wdata[15:0];
      end
      if (hit(addr, FPC_DATA_ADDR)) begin
        data_next = wdata[15:0];
      end
      if (hit(addr, FPC_VOLATILE_ADDR)) begin
        vol_prot_next = wdata;
      end
      if (hit(addr, FPC_PERSIST_ADDR)) begin
        per_prot_next = wdata;
      end
    end

    // Reads; unmapped addresses return zero
    if (rd_stb) begin
      if (hit(addr, FPC_STATUS_ADDR)) begin
        rdata_next = {16'h0000, FPC_STATUS_RST | {12'h000, status_reg}};
        status_next[FPC_ST_IRQ]  = 1'b0;
        status_next[FPC_ST_FAIL] = 1'b0;
        status_next[FPC_ST_PASS] = 1'b0;
      end else if (hit(addr, FPC_MODE_ADDR)) begin
        rdata_next = {16'h0000, mode_reg};
      end else if (hit(addr, FPC_ADDRESS_ADDR)) begin
        rdata_next = {16'h0000, addr_reg};
      end else if (hit(addr, FPC_DATA_ADDR)) begin
        rdata_next = {16'h0000, data_reg};
      end else if (hit(addr, FPC_VOLATILE_ADDR)) begin
        rdata_next = vol_prot_reg;
      end else if (hit(addr, FPC_PERSIST_ADDR)) begin
        rdata_next = per_prot_reg;
      end else if (hit(addr, FPC_COMMAND_ADDR)) begin
        rdata_next = {24'h000000, cmd_reg};
      end
    end

    // Busy from acceptance to the completion flag
    if (cmd_wr) begin
      status_next[FPC_ST_BUSY] = 1'b1;
    end

    // Completion sets after the read clear, so a same-cycle event survives
    if ((state_reg == FPC_RUN) && timer_done) begin
      status_next[FPC_ST_BUSY] = 1'b0;
      status_next[FPC_ST_PASS] = status_next[FPC_ST_PASS] | cmd_ok_reg;
      status_next[FPC_ST_FAIL] = status_next[FPC_ST_FAIL] | !cmd_ok_reg;
      if (mode_reg[FPC_MD_IRQEN]) begin
        status_next[FPC_ST_IRQ] = 1'b1;
      end
    end
  end

  // Software registers; volatile protection clears on reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg      <= FPC_MODE_RST;
      addr_reg      <= 16'h0000;
      data_reg      <= 16'h0000;
      vol_prot_reg  <= FPC_PROT_RST;
      per_prot_reg  <= FPC_PROT_RST;
      act_prot_reg  <= FPC_PROT_RST;
      loaded_reg    <= 1'b0;
      status_reg    <= 4'h0;
      rdata_reg     <= 32'h00000000;
      arr_start_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      addr_reg      <= addr_next;
      data_reg      <= data_next;
      vol_prot_reg  <= vol_prot_next;
      per_prot_reg  <= per_prot_next;
      act_prot_reg  <= act_prot_next;
      loaded_reg    <= loaded_next;
      status_reg    <= status_next;
      rdata_reg     <= rdata_next;
      arr_start_reg <= arr_start_next;
    end
  end

  // Protection outputs for the debug port and other write paths
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg   <= 31'h00000000;
      jtag_reg <= 1'b0;
    end else begin
      wp_reg   <= eff_prot[FPC_GROUPS-1:0];
      jtag_reg <= eff_prot[FPC_JTAG_BIT];
    end
  end

  assign rdata          = rdata_reg;
  assign flash_irq      = status_reg[FPC_ST_IRQ];
  assign jtag_read_lock = jtag_reg;
  assign write_protect  = wp_reg;
  assign array_start    = arr_start_reg;
  assign array_op       = op_reg;
  assign array_addr     = addr_reg;
  assign array_data     = data_reg;

endmodule

//--- fpc_top_properties.sv
// Concurrent port checks of the flash protection controller, with bind
`timescale 1ns/10ps
module fpc_top_checker
  import fpc_pkg::*;
#(
  parameter int CMD_CYC = CMD_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        por_b,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic        flash_irq,
  input wire logic        jtag_read_lock,
  input wire logic [30:0] write_protect,
  input wire logic        array_start,
  input wire logic [1:0]  array_op,
  input wire logic [15:0] array_addr,
  input wire logic [15:0] array_data
);
  // One clock domain, system reset masks all checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Command write as taken by the port
  sequence s_cmd_wr;
    wr_stb && addr == FPC_COMMAND_ADDR;
  endsequence

  // Status read, which also clears the sticky flags
  sequence s_stat_rd;
    rd_stb && addr == FPC_STATUS_ADDR;
  endsequence

  // Volatile write that sets the debug read lock
  sequence s_lock_wr;
    wr_stb && addr == FPC_VOLATILE_ADDR && wdata[31];
  endsequence

  chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_start_pulse: assert property (array_start |=> !array_start)
    else $error("array start longer than one cycle");
  chk_start_cause: assert property (
    array_start |-> $past(wr_stb) && $past(addr) == FPC_COMMAND_ADDR)
    else $error("array start without a command write");
  chk_start_guard: assert property (
    array_start && (array_op == FPC_OP_WRITE || array_op == FPC_OP_PERAS)
    |-> array_addr[15:11] != 5'h1F && !write_protect[array_addr[15:11]])
    else $error("array write started on a protected group");
  chk_irq_hold: assert property (
    flash_irq && !(rd_stb && addr == FPC_STATUS_ADDR) |=> flash_irq)
    else $error("interrupt flag dropped without a status read");
  chk_status_fields: assert property (
    s_stat_rd |=> rdata[31:4] == 28'h0000002 && rdata[3] == $past(flash_irq))
    else $error("status read shows wrong reserved bits or flag");
  chk_mode_upper: assert property (rd_stb && addr == FPC_MODE_ADDR |=> rdata[31:9] == 23'h0)
    else $error("mode read shows bits above 8");
  chk_unmapped_zero: assert property (rd_stb && addr == 32'hFFFFF814 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_vol_lock: assert property (s_lock_wr |-> ##[1:2] jtag_read_lock)
    else $error("debug read lock not set by volatile write");

  // Main scenario reached
  cov_cmd: cover property (s_cmd_wr ##1 array_start);
endmodule

bind fpc_top fpc_top_checker #(.CMD_CYC(CMD_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .por_b(por_b), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .flash_irq(flash_irq),
  .jtag_read_lock(jtag_read_lock), .write_protect(write_protect),
  .array_start(array_start), .array_op(array_op), .array_addr(array_addr),
  .array_data(array_data)
);

//--- tb_flash_protection_control.sv
// Self-checking testbench of the flash protection controller
`timescale 1ns/10ps
module tb_flash_protection_control import fpc_pkg::*;;
  localparam int TB_CMD = 2;  // Short command time keeps the run brief
  logic        clk;
  logic        rst_b;
  logic        por_b;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic        flash_irq;
  logic        jtag_read_lock;
  logic [30:0] write_protect;
  logic        array_start;
  logic [1:0]  array_op;
  logic [15:0] array_addr;
  logic [15:0] array_data;
  int          mismatches;
  int          cmp_count;

  fpc_top #(.CMD_CYC(TB_CMD)) dut (
    .clk(clk), .rst_b(rst_b), .por_b(por_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .flash_irq(flash_irq),
    .jtag_read_lock(jtag_read_lock), .write_protect(write_protect),
    .array_start(array_start), .array_op(array_op), .array_addr(array_addr),
    .array_data(array_data)
  );

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  // One-cycle write; a gap edge follows so strobes never double up
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // One-cycle read; data taken in the following cycle only
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Issue a command, watch busy, irq pin, final flags and their clearing
  task automatic do_cmd(input logic [7:0] c, input logic s, input logic [31:0] e);
    logic [31:0] st;
    int          n;
    wr_reg(FPC_COMMAND_ADDR, {24'h0, c});
    #1;
    check("array_start", {31'h0, s}, {31'h0, array_start});
    rd_reg(FPC_STATUS_ADDR, st);
    check("busy", 32'h1, {31'h0, st[FPC_ST_BUSY]});
    repeat (TB_CMD - 1) @(posedge clk);
    #1;
    check("flash_irq", {31'h0, e[FPC_ST_IRQ]}, {31'h0, flash_irq});
    n = 0;
    do begin
      rd_reg(FPC_STATUS_ADDR, st);
      n++;
    end while (st[FPC_ST_BUSY] !== 1'b0 && n < 20);
    if (st[FPC_ST_BUSY] !== 1'b0) begin
      mismatches++;
      $display("unexpected busy: expected 0, seen 1");
      finish_test();
    end
    check("status", e, st);
    rd_reg(FPC_STATUS_ADDR, st);
    check("status cleared", 32'h20, st);
  endtask

  // Protection seen at the pins one edge later
  task automatic chk_prot(input logic [31:0] e);
    @(posedge clk);
    #1;
    check("protect", e, {jtag_read_lock, write_protect});
  endtask

  // System reset only; the key store survives it
  task automatic sys_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Persistent word, mode and 32-bit key loaded before a save
  task automatic set_key(input logic [31:0] p, input logic [15:0] m, input logic [31:0] k);
    wr_reg(FPC_PERSIST_ADDR, p);
    wr_reg(FPC_MODE_ADDR, {16'h0, m});
    wr_reg(FPC_ADDRESS_ADDR, {16'h0, k[31:16]});
    wr_reg(FPC_DATA_ADDR, {16'h0, k[15:0]});
  endtask

  // Reset values, read-only status, mode width, unmapped hole
  task automatic t_regs;
    logic [31:0] v;
    rd_reg(FPC_STATUS_ADDR, v);
    check("status reset", 32'h20, v);
    rd_reg(FPC_MODE_ADDR, v);
    check("mode reset", 32'h0, v);
    wr_reg(FPC_STATUS_ADDR, 32'h0000FFFF);
    rd_reg(FPC_STATUS_ADDR, v);
    check("status write", 32'h20, v);
    wr_reg(FPC_MODE_ADDR, 32'h0000FE18);
    rd_reg(FPC_MODE_ADDR, v);
    check("mode width", 32'h18, v);
    rd_reg(32'hFFFFF814, v);
    check("unmapped", 32'h0, v);
    $display("test regs done");
  endtask

  // Read, write, page erase, mass erase and an unknown code under the write and interrupt enables
  task automatic t_codes;
    logic [7:0]  code [9] = '{8'h02, 8'h05, 8'h02, 8'h05, 8'h06, 8'h01, 8'h7F, 8'h02, 8'h06};
    logic [7:0]  md   [9] = '{8'h08, 8'h08, 8'h10, 8'h00, 8'h00, 8'h00, 8'h08, 8'h18, 8'h08};
    logic        st   [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [7:0]  res  [9] = '{8'h21, 8'h21, 8'h2A, 8'h22, 8'h22, 8'h21, 8'h22, 8'h29, 8'h21};
    logic [1:0]  op   [9] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 9; i++) begin
      wr_reg(FPC_MODE_ADDR, {24'h0, md[i]});
      wr_reg(FPC_ADDRESS_ADDR, 32'h0800);
      do_cmd(code[i], st[i], {24'h0, res[i]});
      if (st[i])
        check("array_op", {30'h0, op[i]}, {30'h0, array_op});
    end
    $display("test codes done");
  endtask

  // Volatile protection: instant, per group, lost on reset
  task automatic t_volatile;
    wr_reg(FPC_VOLATILE_ADDR, 32'h80000002);
    chk_prot(32'h80000002);
    wr_reg(FPC_MODE_ADDR, 32'h08);
    wr_reg(FPC_ADDRESS_ADDR, 32'h0800);
    do_cmd(FPC_CMD_WRITE, 1'b0, 32'h22);
    wr_reg(FPC_ADDRESS_ADDR, 32'h1000);
    do_cmd(FPC_CMD_PERAS, 1'b1, 32'h21);
    wr_reg(FPC_ADDRESS_ADDR, 32'hF800);
    do_cmd(FPC_CMD_WRITE, 1'b0, 32'h22);
    wr_reg(FPC_VOLATILE_ADDR, 32'h0);
    chk_prot(32'h0);
    wr_reg(FPC_VOLATILE_ADDR, 32'h1);
    sys_reset();
    chk_prot(32'h0);
    $display("test volatile done");
  endtask

  // Key save, wrong key, permanent key, mass erase recovery
  task automatic t_key;
    set_key(32'h4, 16'h48, 32'h12345678);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h21);
    check("array word", 32'h12345678, {array_addr, array_data});
    chk_prot(32'h0);
    sys_reset();
    chk_prot(32'h4);
    set_key(32'h0, 16'h48, 32'h11115678);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h22);
    set_key(32'h0, 16'h68, 32'h12345678);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h22);
    set_key(32'h8, 16'h48, 32'h12345678);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h21);
    // Only a blank store takes a new key, so erase before the permanent one
    wr_reg(FPC_MODE_ADDR, 32'h08);
    do_cmd(FPC_CMD_MERAS, 1'b1, 32'h21);
    set_key(32'h8, 16'h48, FPC_KEY_PERM);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h21);
    sys_reset();
    chk_prot(32'h8);
    set_key(32'h0, 16'h48, FPC_KEY_PERM);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h22);
    wr_reg(FPC_MODE_ADDR, 32'h08);
    do_cmd(FPC_CMD_MERAS, 1'b1, 32'h21);
    sys_reset();
    chk_prot(32'h0);
    set_key(32'h0, 16'h48, 32'hAAAA5555);
    do_cmd(FPC_CMD_SAVE, 1'b0, 32'h21);
    $display("test key done");
  endtask

  // Counts, verdict and end of run
  task automatic finish_test;
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: both resets held, then the scenarios
  initial begin
    rst_b  = 1'b0;
    por_b  = 1'b0;
    addr   = 32'h0;
    wdata  = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_codes();
    t_volatile();
    t_key();
    finish_test();
  end
endmodule
